/* hdl/srs_pkg.sv */
// Shared constants and types for the serial receive sequencer.
// Assumes a 100 MHz ref_clk and a 16-bit register port with byte addresses.
package srs_pkg;
    localparam int unsigned CLK_NS    = 10;
    localparam int unsigned RST_NS    = 500;
    localparam logic [7:0]  RST_CYC   = 8'((RST_NS + CLK_NS - 1) / CLK_NS);
    // Receiver bit time in clocks; default is 115200 baud
    localparam logic [15:0] BIT_CYC   = 16'h0364;

    localparam logic [7:0]  REG_CTRL  = 8'h00;
    localparam logic [7:0]  REG_COUNT = 8'h04;
    localparam logic [7:0]  REG_STAT  = 8'h08;
    localparam logic [7:0]  REG_MASK  = 8'h0C;
    localparam logic [7:0]  REG_DATA  = 8'h10;
    localparam logic [7:0]  REG_STATE = 8'h14;

    // Control register fields
    localparam int unsigned C_DTR_N   = 0;
    localparam int unsigned C_RTS     = 1;
    localparam int unsigned C_ECHO    = 3;
    localparam int unsigned C_BR_LO   = 4;
    localparam int unsigned C_RESET   = 8;
    localparam int unsigned C_BEGIN   = 9;
    localparam logic [3:0]  BR_START  = 4'h1;
    localparam logic [3:0]  BR_RING   = 4'h3;
    localparam logic [3:0]  BR_RINGIN = 4'h4;
    localparam logic [3:0]  MODE_RST  = 4'h0;

    // Status and mask fields
    localparam int unsigned S_DS      = 0;
    localparam int unsigned S_EOB     = 1;
    localparam int unsigned S_NOCAR   = 2;
    localparam int unsigned S_POERR   = 3;
    localparam int unsigned S_FRERR   = 4;
    localparam int unsigned S_DONE    = 5;
    localparam int unsigned S_W       = 6;
    localparam logic [5:0]  STAT_RST  = 6'h00;
    localparam logic [5:0]  MASK_RST  = 6'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_RING, ST_RST, ST_NEXT, ST_WAIT, ST_DS,
        ST_CHK_PO, ST_CLR, ST_CHK_FE, ST_EOB
    } srs_state_e;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} srs_rx_e;
endpackage

/* hdl/srs_rx_if.sv */
// Link between the sequencer and its serial receiver.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface srs_rx_if;
    logic       rst_pulse;
    logic       clr_ready;
    logic       ready;
    logic [7:0] data;
    logic       po_err;
    logic       fr_err;
    modport seq (output rst_pulse, output clr_ready,
                 input ready, input data, input po_err, input fr_err);
    modport rx  (input rst_pulse, input clr_ready,
                 output ready, output data, output po_err, output fr_err);
endinterface

/* hdl/srs_rx.sv */
// Serial receiver: 8 data bits, even parity, one stop bit, LSB first.
// Assumes serial_rx_line is synchronous to ref_clk and idles high.
`timescale 1ns/1ps
module srs_rx (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic serial_rx_line,
    srs_rx_if.rx      bus
);
    srs_pkg::srs_rx_e st_ff;
    logic [15:0]      tick_ff;
    logic [3:0]       bit_ff;
    logic [8:0]       sh_ff;

    wire tick_end = (tick_ff == 16'h0000);
    wire par_bad  = ^sh_ff;
    wire char_end = (st_ff == srs_pkg::RX_STOP) && tick_end;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff      <= srs_pkg::RX_IDLE;
            tick_ff    <= 16'h0000;
            bit_ff     <= 4'h0;
            sh_ff      <= 9'h000;
            bus.ready  <= 1'b0;
            bus.data   <= 8'h00;
            bus.po_err <= 1'b0;
            bus.fr_err <= 1'b0;
        end else if (ce) begin
            if (bus.rst_pulse) begin
                st_ff      <= srs_pkg::RX_IDLE;
                bus.ready  <= 1'b0;
                bus.po_err <= 1'b0;
                bus.fr_err <= 1'b0;
            end else begin
                tick_ff <= tick_end ? tick_ff : tick_ff - 16'h0001;
                unique case (st_ff)
                    srs_pkg::RX_IDLE: if (!serial_rx_line) begin
                        st_ff   <= srs_pkg::RX_START;
                        tick_ff <= {1'b0, srs_pkg::BIT_CYC[15:1]};
                    end
                    srs_pkg::RX_START: if (tick_end) begin
                        // A glitch shorter than half a bit is not a start
                        st_ff   <= serial_rx_line ? srs_pkg::RX_IDLE : srs_pkg::RX_BITS;
                        tick_ff <= srs_pkg::BIT_CYC;
                        bit_ff  <= 4'h0;
                    end
                    srs_pkg::RX_BITS: if (tick_end) begin
                        sh_ff   <= {serial_rx_line, sh_ff[8:1]};
                        tick_ff <= srs_pkg::BIT_CYC;
                        bit_ff  <= bit_ff + 4'h1;
                        if (bit_ff == 4'h8)
                            st_ff <= srs_pkg::RX_STOP;
                    end
                    srs_pkg::RX_STOP: if (tick_end)
                        st_ff <= srs_pkg::RX_IDLE;
                endcase
                if (char_end) begin
                    bus.data   <= sh_ff[7:0];
                    bus.ready  <= 1'b1;
                    // Overrun: previous character never taken
                    bus.po_err <= par_bad | (bus.ready & ~bus.clr_ready);
                    bus.fr_err <= ~serial_rx_line;
                end else if (bus.clr_ready) begin
                    bus.ready  <= 1'b0;
                end
            end
        end
    end
endmodule

/* hdl/srs_seq.sv */
// Receive sequencer top: register port, handshake lines, receiver instance.
// Assumes all inputs are synchronous to ref_clk; register read data one cycle late.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module srs_seq (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        serial_rx_line,
    output logic             serial_tx_line,
    input  wire logic        carrier_present,
    input  wire logic        cts,
    input  wire logic        dsr,
    output logic             dtr,
    output logic             rts,
    output logic             ring,
    output logic             irq
);
    srs_rx_if rx ();

    srs_rx u_rx (
        .ref_clk        (ref_clk),
        .rstn           (rstn),
        .ce             (ce),
        .serial_rx_line (serial_rx_line),
        .bus            (rx.rx)
    );

    srs_pkg::srs_state_e          state_ff;
    srs_pkg::srs_state_e          nxt_state;
    logic [3:0]                   mode_ff;
    logic                         ring_only_ff;
    logic [15:0]                  count_ff;
    logic [7:0]                   pulse_ff;
    logic [srs_pkg::S_W-1:0]      stat_ff;
    logic [srs_pkg::S_W-1:0]      mask_ff;
    logic [srs_pkg::S_W-1:0]      ev_set;
    logic [15:0]                  rd_mux;

    // Bus decode, all gated by the clock enable
    wire wr_ctrl  = ce && reg_wr && (reg_addr == srs_pkg::REG_CTRL);
    wire wr_count = ce && reg_wr && (reg_addr == srs_pkg::REG_COUNT);
    wire wr_mask  = ce && reg_wr && (reg_addr == srs_pkg::REG_MASK);
    wire rd_stat  = ce && reg_rd && (reg_addr == srs_pkg::REG_STAT);
    wire rd_data  = ce && reg_rd && (reg_addr == srs_pkg::REG_DATA);
    wire cmd_rst  = wr_ctrl && reg_wdata[srs_pkg::C_RESET];
    wire cmd_beg  = wr_ctrl && reg_wdata[srs_pkg::C_BEGIN] && !cmd_rst;
    wire [3:0] br = reg_wdata[srs_pkg::C_BR_LO +: 4];
    wire in_idle  = (state_ff == srs_pkg::ST_IDLE);
    wire ds_take  = rd_data && (state_ff == srs_pkg::ST_DS);
    wire last_one = (count_ff <= 16'h0001);
    wire eob_ack  = rd_stat && stat_ff[srs_pkg::S_EOB];

    // Sequencer next state and its interrupt causes
    always_comb begin
        nxt_state = state_ff;
        ev_set    = '0;
        unique case (state_ff)
            srs_pkg::ST_IDLE:
                if (cmd_beg && br == srs_pkg::BR_START)
                    nxt_state = srs_pkg::ST_RST;
                else if (cmd_beg && (br == srs_pkg::BR_RING || br == srs_pkg::BR_RINGIN))
                    nxt_state = srs_pkg::ST_RING;
            srs_pkg::ST_RING:
                if (dsr)
                    nxt_state = ring_only_ff ? srs_pkg::ST_EOB : srs_pkg::ST_RST;
            srs_pkg::ST_RST:
                if (pulse_ff == 8'h01)
                    nxt_state = srs_pkg::ST_NEXT;
            srs_pkg::ST_NEXT:
                if (!rx.ready) begin
                    nxt_state = carrier_present ? srs_pkg::ST_WAIT : srs_pkg::ST_EOB;
                    ev_set[srs_pkg::S_NOCAR] = !carrier_present;
                end
            srs_pkg::ST_WAIT:
                if (rx.ready) begin
                    nxt_state = srs_pkg::ST_DS;
                    ev_set[srs_pkg::S_DS] = 1'b1;
                end else if (!carrier_present) begin
                    nxt_state = srs_pkg::ST_EOB;
                    ev_set[srs_pkg::S_NOCAR] = 1'b1;
                end
            srs_pkg::ST_DS:
                if (ds_take) begin
                    nxt_state = last_one ? srs_pkg::ST_EOB : srs_pkg::ST_CHK_PO;
                    ev_set[srs_pkg::S_DONE] = last_one;
                end
            srs_pkg::ST_CHK_PO: begin
                nxt_state = rx.po_err ? srs_pkg::ST_EOB : srs_pkg::ST_CLR;
                ev_set[srs_pkg::S_POERR] = rx.po_err;
            end
            srs_pkg::ST_CLR:
                nxt_state = srs_pkg::ST_CHK_FE;
            srs_pkg::ST_CHK_FE: begin
                nxt_state = rx.fr_err ? srs_pkg::ST_EOB : srs_pkg::ST_NEXT;
                ev_set[srs_pkg::S_FRERR] = rx.fr_err;
            end
            srs_pkg::ST_EOB:
                if (eob_ack)
                    nxt_state = srs_pkg::ST_IDLE;
        endcase
        if (cmd_rst)
            nxt_state = srs_pkg::ST_IDLE;
        ev_set[srs_pkg::S_EOB] = (nxt_state == srs_pkg::ST_EOB) &&
                                 (state_ff != srs_pkg::ST_EOB);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff     <= srs_pkg::ST_IDLE;
            mode_ff      <= srs_pkg::MODE_RST;
            ring_only_ff <= 1'b0;
            pulse_ff     <= 8'h00;
        end else if (ce) begin
            state_ff <= nxt_state;
            // Mode bits change only in idle or on the reset command
            if (cmd_rst)
                mode_ff <= srs_pkg::MODE_RST;
            else if (wr_ctrl && in_idle)
                mode_ff <= reg_wdata[3:0];
            if (cmd_beg && in_idle)
                ring_only_ff <= (br == srs_pkg::BR_RING);
            pulse_ff <= (nxt_state == srs_pkg::ST_RST && state_ff != srs_pkg::ST_RST)
                        ? srs_pkg::RST_CYC : pulse_ff - {7'h00, |pulse_ff};
        end
    end

    // Count: host load in idle, decrement per transfer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            count_ff <= srs_pkg::COUNT_RST;
        else if (ds_take && !last_one)
            count_ff <= count_ff - 16'h0001;
        else if (ds_take)
            count_ff <= 16'h0000;
        else if (wr_count && in_idle)
            count_ff <= reg_wdata;
    end

    // Sticky status; an event in the clearing read's cycle survives
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stat_ff <= srs_pkg::STAT_RST;
            mask_ff <= srs_pkg::MASK_RST;
        end else if (ce) begin
            stat_ff <= (rd_stat ? '0 : stat_ff) | ev_set;
            if (wr_mask)
                mask_ff <= reg_wdata[srs_pkg::S_W-1:0];
        end
    end

    assign rx.rst_pulse = (state_ff == srs_pkg::ST_RST);
    assign rx.clr_ready = (state_ff == srs_pkg::ST_CLR);

    always_comb begin
        unique case (reg_addr)
            srs_pkg::REG_CTRL:  rd_mux = {12'h000, mode_ff};
            srs_pkg::REG_COUNT: rd_mux = count_ff;
            srs_pkg::REG_STAT:  rd_mux = {10'h000, stat_ff};
            srs_pkg::REG_MASK:  rd_mux = {10'h000, mask_ff};
            srs_pkg::REG_DATA:  rd_mux = {8'h00, rx.data};
            srs_pkg::REG_STATE: rd_mux = {8'h00, cts, dsr, carrier_present, rx.ready,
                                          4'(state_ff)};
            default:            rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata      <= 16'h0000;
            dtr            <= 1'b1;
            rts            <= 1'b0;
            ring           <= 1'b0;
            irq            <= 1'b0;
            serial_tx_line <= 1'b1;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
            dtr       <= ~mode_ff[srs_pkg::C_DTR_N];
            rts       <= mode_ff[srs_pkg::C_RTS];
            ring      <= (nxt_state == srs_pkg::ST_RING);
            irq       <= |(((rd_stat ? '0 : stat_ff) | ev_set) & mask_ff);
            // Echo mode loops the receive line back; otherwise mark idle
            serial_tx_line <= mode_ff[srs_pkg::C_ECHO] ? serial_rx_line : 1'b1;
        end
    end

    // Checking
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    logic [7:0] plen_ff;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            plen_ff <= 8'h00;
        else if (ce)
            plen_ff <= rx.rst_pulse ? plen_ff + 8'h01 : 8'h00;
    end

    sequence s_po_ok;
        ce && state_ff == srs_pkg::ST_CHK_PO && !rx.po_err && !cmd_rst;
    endsequence
    sequence s_clear_then_fe;
        rx.clr_ready ##1 state_ff == srs_pkg::ST_CHK_FE;
    endsequence

    a_pulse_len_ok: assert property (
        ce && rx.rst_pulse && !cmd_rst && nxt_state != srs_pkg::ST_RST
        |-> plen_ff == srs_pkg::RST_CYC - 8'h01)
        else $error("receiver reset pulse length wrong");
    a_no_carrier_eob: assert property (
        ce && state_ff == srs_pkg::ST_NEXT && !rx.ready && !carrier_present && !cmd_rst
        |=> state_ff == srs_pkg::ST_EOB && stat_ff[srs_pkg::S_NOCAR])
        else $error("missing carrier did not end block");
    a_drop_eob: assert property (
        ce && state_ff == srs_pkg::ST_WAIT && !rx.ready && !carrier_present && !cmd_rst
        |=> state_ff == srs_pkg::ST_EOB && stat_ff[srs_pkg::S_EOB])
        else $error("carrier drop did not end block");
    a_ds_raise: assert property (
        ce && state_ff == srs_pkg::ST_WAIT && rx.ready && !cmd_rst
        |=> state_ff == srs_pkg::ST_DS && stat_ff[srs_pkg::S_DS])
        else $error("data service not raised");
    a_check_order: assert property (
        s_po_ok ##1 (ce && !cmd_rst) |-> s_clear_then_fe)
        else $error("error checks out of order");
    a_loop_next: assert property (
        ce && state_ff == srs_pkg::ST_CHK_FE && !rx.fr_err && !cmd_rst
        |=> state_ff == srs_pkg::ST_NEXT)
        else $error("did not return to next input");
    a_last_eob: assert property (
        ds_take && last_one && !cmd_rst
        |=> state_ff == srs_pkg::ST_EOB && stat_ff[srs_pkg::S_DONE])
        else $error("final byte did not end block");
    a_eob_idle: assert property (
        ce && state_ff == srs_pkg::ST_EOB && eob_ack |=> state_ff == srs_pkg::ST_IDLE)
        else $error("serviced end of block did not idle");
    a_dtr_mode: assert property (
        wr_ctrl && in_idle && !reg_wdata[srs_pkg::C_DTR_N] && !cmd_rst ##1 ce |=> dtr)
        else $error("terminal ready not asserted");
    a_ringin_start: assert property (
        ce && state_ff == srs_pkg::ST_RING && dsr && !ring_only_ff && !cmd_rst
        |=> rx.rst_pulse)
        else $error("ring-in did not start input");
    a_count_dec: assert property (
        ds_take && !last_one |=> count_ff == $past(count_ff) - 16'h0001)
        else $error("byte count not decremented");

    // Holding steps: nothing moves until its awaited condition
    a_next_hold: assert property (
        ce && state_ff == srs_pkg::ST_NEXT && rx.ready && !cmd_rst
        |=> state_ff == srs_pkg::ST_NEXT)
        else $error("left next input while receiver still full");
    a_wait_hold: assert property (
        ce && state_ff == srs_pkg::ST_WAIT && !rx.ready && carrier_present && !cmd_rst
        |=> state_ff == srs_pkg::ST_WAIT)
        else $error("left wait step without character or carrier loss");

    // Error exits of the checking steps, and the emptied count after the last transfer
    a_po_eob: assert property (
        ce && state_ff == srs_pkg::ST_CHK_PO && rx.po_err && !cmd_rst
        |=> state_ff == srs_pkg::ST_EOB && stat_ff[srs_pkg::S_POERR])
        else $error("parity or overrun did not end block");
    a_fe_eob: assert property (
        ce && state_ff == srs_pkg::ST_CHK_FE && rx.fr_err && !cmd_rst
        |=> state_ff == srs_pkg::ST_EOB && stat_ff[srs_pkg::S_FRERR])
        else $error("framing error did not end block");
    a_count_zero: assert property (
        ds_take && last_one |=> count_ff == 16'h0000)
        else $error("final transfer did not empty count");

    // DTR rises and RTS follows the mode bits one cycle later; ring tracks the ring state
    a_dtr_follow: assert property (
        ce && !mode_ff[srs_pkg::C_DTR_N] |=> dtr)
        else $error("terminal ready not following mode");
    a_rts_on: assert property (
        ce && mode_ff[srs_pkg::C_RTS] |=> rts)
        else $error("request to send not raised");
    a_rts_off: assert property (
        ce && !mode_ff[srs_pkg::C_RTS] |=> !rts)
        else $error("request to send not dropped");
    a_ring_state: assert property (
        ring == (state_ff == srs_pkg::ST_RING))
        else $error("ring line out of step with sequencer");

    // Interrupt level and the reset command
    a_irq_level: assert property (
        ce && !wr_mask |=> irq == |(stat_ff & mask_ff))
        else $error("interrupt level does not match status");
    a_cmd_idle: assert property (
        cmd_rst |=> state_ff == srs_pkg::ST_IDLE && !rx.rst_pulse)
        else $error("reset command did not idle");
endmodule

/* verif/srs_far_end.sv */
// Far-end model: RS232 terminal or modem feeding the receive side.
// Assumes ref_clk sets bit timing; the bench steers car_on and dsr_wait by hierarchy.
`timescale 1ns/1ps
module srs_far_end (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic dtr,
    input  wire logic ring,
    output logic      serial_rx_line,
    output logic      carrier_present,
    output logic      cts,
    output logic      dsr
);
    logic       car_on;
    logic [7:0] dsr_wait;
    logic [7:0] ring_cnt;

    initial begin
        serial_rx_line = 1'b1;
        car_on = 1'b0;
        dsr_wait = 8'h04;
    end

    assign carrier_present = car_on;
    // Terminal takes data whenever the host side says it is ready
    assign cts = dtr;

    // Answer a ring after dsr_wait cycles; hang up once ring and carrier are gone
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ring_cnt <= 8'h00;
            dsr <= 1'b0;
        end else if (ring) begin
            ring_cnt <= ring_cnt + 8'h01;
            if (ring_cnt == dsr_wait) begin
                dsr <= 1'b1;
            end
        end else if (!car_on) begin
            ring_cnt <= 8'h00;
            dsr <= 1'b0;
        end
    end

    // Start, 8 data bits LSB first, even parity, stop; line idles at mark
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] fr;
        fr = {~bad_stop, (^d) ^ bad_par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            serial_rx_line <= fr[i];
            repeat (srs_pkg::BIT_CYC) @(posedge ref_clk);
        end
        serial_rx_line <= 1'b1;
    endtask
endmodule

/* verif/serial_receive_sequencer_test.sv */
// Self-checking bench for the receive sequencer with a far-end model.
// Assumes the package bit time; each character costs about 9600 cycles.
`timescale 1ns/1ps
module serial_receive_sequencer_test;
    localparam logic [7:0] A_CT = srs_pkg::REG_CTRL;
    localparam logic [7:0] A_CN = srs_pkg::REG_COUNT;
    localparam logic [7:0] A_SS = srs_pkg::REG_STAT;
    localparam logic [7:0] A_MK = srs_pkg::REG_MASK;
    localparam logic [7:0] A_DT = srs_pkg::REG_DATA;
    localparam logic [7:0] A_ST = srs_pkg::REG_STATE;
    localparam int         LIMIT = 90000;

    logic        ref_clk;
    logic        rstn;
    logic        ce;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        serial_rx_line;
    logic        serial_tx_line;
    logic        carrier_present;
    logic        cts;
    logic        dsr;
    logic        dtr;
    logic        rts;
    logic        ring;
    logic        irq;
    int          tests_run;
    int          n_mismatch;
    int          cyc;

    srs_seq u_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line),
        .carrier_present(carrier_present), .cts(cts), .dsr(dsr), .dtr(dtr), .rts(rts),
        .ring(ring), .irq(irq));
    srs_far_end u_far (.ref_clk(ref_clk), .rstn(rstn), .dtr(dtr), .ring(ring),
        .serial_rx_line(serial_rx_line), .carrier_present(carrier_present), .cts(cts),
        .dsr(dsr));

    always #5 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard: a run past the ceiling counts as a mismatch
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe is taken
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    task automatic wait_st(input logic [3:0] code);
        logic [15:0] d;
        int n;
        n = 0;
        d = 16'h0000;
        do begin
            rd(A_ST, d);
            n++;
        end while (d[3:0] !== code && n < 6000);
        chk({12'h000, d[3:0]}, {12'h000, code});
    endtask

    task automatic start(input logic [3:0] br, input logic [15:0] cnt);
        wr(A_CN, cnt);
        wr(A_CT, 16'h0200 | {8'h00, br, 4'h0});
    endtask

    task automatic t_reset();
        chk({12'h000, dtr, rts, ring, irq}, 16'h0008);
        chk({15'h0000, serial_tx_line}, 16'h0001);
        rchk(A_SS, 16'h0000);
        rchk(A_MK, 16'h0000);
        rchk(8'h1C, 16'h0000);
        @(posedge ref_clk);
        ce <= 1'b0;
        wr(A_CN, 16'h0005);
        ce <= 1'b1;
        rchk(A_CN, 16'h0000);
        $display("t_reset done");
    endtask

    task automatic t_modes();
        logic [15:0] d;
        wr(A_CT, 16'h000B);
        u_far.serial_rx_line <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk({14'h0000, dtr, rts}, 16'h0001);
        chk({15'h0000, serial_tx_line}, 16'h0000);
        u_far.serial_rx_line <= 1'b1;
        rchk(A_CT, 16'h000B);
        rd(A_ST, d);
        chk(d & 16'h0080, 16'h0000);
        wr(A_CT, 16'h0000);
        @(posedge ref_clk);
        #1 chk({14'h0000, dtr, rts}, 16'h0002);
        $display("t_modes done");
    endtask

    task automatic t_block();
        logic [15:0] d;
        int n;
        wr(A_MK, 16'h003F);
        u_far.car_on <= 1'b1;
        start(srs_pkg::BR_START, 16'h0002);
        n = 0;
        d = 16'h0002;
        while (d[3:0] === 4'h2 && n < 100) begin
            rd(A_ST, d);
            n++;
        end
        chk({15'h0000, n >= 24 && n <= 27}, 16'h0001);
        wait_st(4'h4);
        u_far.send(8'hA5, 1'b0, 1'b0);
        wait_st(4'h5);
        chk({15'h0000, irq}, 16'h0001);
        rchk(A_SS, 16'h0001);
        rchk(A_DT, 16'h00A5);
        wait_st(4'h4);
        rchk(A_CN, 16'h0001);
        rchk(A_SS, 16'h0000);
        u_far.send(8'h3C, 1'b0, 1'b0);
        wait_st(4'h5);
        rchk(A_DT, 16'h003C);
        rchk(A_ST, 16'h00B9);
        rchk(A_SS, 16'h0023);
        rd(A_ST, d);
        chk(d & 16'h000F, 16'h0000);
        $display("t_block done");
    endtask

    task automatic t_err(input logic bp, input logic bs, input logic [15:0] bit_exp);
        start(srs_pkg::BR_START, 16'h0002);
        wait_st(4'h4);
        u_far.send(8'h55, bp, bs);
        wait_st(4'h5);
        rchk(A_DT, 16'h0055);
        wait_st(4'h9);
        rchk(A_SS, 16'h0003 | bit_exp);
        wait_st(4'h0);
        $display("t_err done");
    endtask

    task automatic t_carrier();
        logic [15:0] d;
        u_far.car_on <= 1'b0;
        wr(A_MK, 16'h0001);
        start(srs_pkg::BR_START, 16'h0001);
        wait_st(4'h9);
        chk({15'h0000, irq}, 16'h0000);
        wr(A_MK, 16'h003F);
        @(posedge ref_clk);
        #1 chk({15'h0000, irq}, 16'h0001);
        rchk(A_SS, 16'h0006);
        @(posedge ref_clk);
        #1 chk({15'h0000, irq}, 16'h0000);
        // Reset command aborts the receiver reset step without an interrupt
        start(srs_pkg::BR_START, 16'h0001);
        wr(A_CT, 16'h0100);
        rd(A_ST, d);
        chk(d & 16'h000F, 16'h0000);
        rchk(A_SS, 16'h0000);
        u_far.car_on <= 1'b1;
        start(srs_pkg::BR_START, 16'h0001);
        wait_st(4'h4);
        u_far.car_on <= 1'b0;
        wait_st(4'h9);
        rchk(A_SS, 16'h0006);
        $display("t_carrier done");
    endtask

    task automatic t_ring();
        u_far.dsr_wait = 8'h1E;
        start(srs_pkg::BR_RING, 16'h0000);
        rchk(A_ST, 16'h0081);
        chk({15'h0000, ring}, 16'h0001);
        wait_st(4'h9);
        chk({15'h0000, ring}, 16'h0000);
        rchk(A_SS, 16'h0002);
        u_far.dsr_wait = 8'h02;
        u_far.car_on <= 1'b1;
        start(srs_pkg::BR_RINGIN, 16'h0001);
        wait_st(4'h4);
        u_far.send(8'h81, 1'b0, 1'b0);
        wait_st(4'h5);
        rchk(A_DT, 16'h0081);
        rchk(A_SS, 16'h0023);
        $display("t_ring done");
    endtask

    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tests_run = 0;
        n_mismatch = 0;
        cyc = 0;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_modes();
        t_block();
        t_err(1'b1, 1'b0, 16'h0008);
        t_err(1'b0, 1'b1, 16'h0010);
        t_carrier();
        t_ring();
        report_and_stop();
    end
endmodule
